/* core/rsrc_ctrl.sv */
// Reset and stop-recovery sequencer with AXI4-Lite register slave
// Operation
// - Outside stop, reset pin low four clocks resets; three may; shorter ignored.
// - In stop, pin pulses under 12 ns ignored, longer give full reset.
// - Debugger request resets all but debugger; bit self-clears; power-on flag set.
// - After power good, hold reset until delay; longer with crystal enabled.
// - Leaving power-on reset sets power-on flag and releases processor.
// - Brownout forces reset; recovery runs full power-on sequence.
// - Option bit keeps brownout detection active or off in stop.
// - Watchdog time-out resets when option is 1, else raises interrupt.
// - Watchdog-caused reset sets watchdog cause flag.
// - Stay in reset while pin low; leave on edge after release.
// - Pin-caused reset sets external cause flag.
// - Internal reset drives reset pin low until delay elapses.
// - Wake holds processor about 66 cycles, or 5000 with crystal.
// - Wake touches only cause and oscillator registers; oscillator forced on.
// - Processor fetches vector at 0002H/0003H after reset or wake.
// - Every stop wake sets the stop cause flag.
// - In stop, reset pin or debug pin low gives full reset.
// - Watchdog in stop wakes, sets watchdog and stop; interrupt after wake; code raises it only when the watchdog reset option is 0.
// - Enabled GPIO edge in stop starts wake and sets stop flag.
// - Port inputs frozen in stop, sampled only after wake delay ends.
// - Reading cause register clears its four upper flag bits.
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "rsrc_params.svh"

module rsrc_ctrl #(
    parameter int unsigned GPIO_W = 8,
    parameter int unsigned DLY_W = 13,
    parameter logic [DLY_W-1:0] WAKE_SHORT_CYC = 13'h0042,
    parameter logic [DLY_W-1:0] WAKE_LONG_CYC = 13'h1388
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Register bus
    input wire rsrc_pkg::rsrc_axi_req_s axi_req_i,
    output rsrc_pkg::rsrc_axi_rsp_s axi_rsp_o,
    // Supply monitors
    input wire logic power_good_i,
    input wire logic brownout_detect_i,
    // Reset pin, open drain
    input wire logic reset_pin_i,
    output logic reset_pin_o,
    output logic reset_pin_oe_n_o,
    // Stop entry, wake and reset sources
    input wire logic stop_enter_i,
    input wire logic watchdog_timeout_i,
    input wire logic debug_pin_i,
    input wire logic [GPIO_W-1:0] gpio_i,
    // Processor and chip side
    output logic cpu_reset_o,
    output logic chip_reset_o,
    output logic vector_fetch_o,
    output logic [15:0] vector_addr_o,
    output logic watchdog_irq_o,
    output logic stop_mode_o,
    output logic ipo_enable_o,
    output logic sysclk_ipo_sel_o,
    output logic [GPIO_W-1:0] port_input_registers_o
);
    import rsrc_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    rsrc_state_e state_q;
    rsrc_axi_rsp_s rsp_q;
    rsrc_cause_t pat_q, sys_pat, wake_pat, cause_q;
    logic sys_q, start_q, rel_q, cpu_rst_q, chip_rst_q, pin_oe_n_q, pin_out_q;
    logic pin_s1_q, pin_s2_q, stop_q, dbg_rst_q, irq_q, irq_pend_q;
    logic [2:0] low_cnt_q;
    logic [7:0] opt_q, osc_q;
    logic [GPIO_W-1:0] wake_en_q, gpio_prev_q, port_in_q, gpio_chg;
    logic [15:0] vec_q;
    logic in_run, por_src, ext_hit, sys_evt, wake_evt, wdt_irq_evt, dly_done;
    logic wr_hs, rd_hs, rd_map, wr_map;
    logic [31:0] rd_mux;
    logic [DLY_W-1:0] dly_len;

    // ****************************************
    // Source detection
    // ****************************************

    // Two flops only; nothing else looks at the first one
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end else begin
            pin_s1_q <= reset_pin_i;
            pin_s2_q <= pin_s1_q;
        end
    end

    // Low time counted only in run, where the pin is not our own drive
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            low_cnt_q <= 3'h0;
        end else if (in_run && !pin_s2_q) begin
            low_cnt_q <= (low_cnt_q == 3'h7) ? low_cnt_q : low_cnt_q + 3'h1;
        end else begin
            low_cnt_q <= 3'h0;
        end
    end

    // Event decode, power-on highest priority
    always_comb begin
        in_run = (state_q == RSRC_RUN);
        por_src = !power_good_i
            || (brownout_detect_i && (!stop_q || opt_q[`RSRC_OPT_BO_STOP]));
        ext_hit = stop_q ? (low_cnt_q >= 3'(`RSRC_STOP_GLITCH_CYC))
            : (low_cnt_q >= 3'(`RSRC_RUN_PIN_CYC));
        gpio_chg = (gpio_i ^ gpio_prev_q) & wake_en_q;
        sys_evt = in_run && (por_src || ext_hit || (stop_q && !debug_pin_i)
            || (!stop_q && dbg_rst_q)
            || (!stop_q && watchdog_timeout_i && opt_q[`RSRC_OPT_WATCHDOG_RESET_OPTION]));
        if (por_src) begin
            sys_pat = `RSRC_PAT_POR;
        end else if (ext_hit) begin
            sys_pat = `RSRC_PAT_EXT;
        end else if (stop_q || dbg_rst_q) begin
            sys_pat = `RSRC_PAT_POR;
        end else begin
            sys_pat = `RSRC_PAT_WDT;
        end
        wake_evt = in_run && stop_q && !sys_evt && (watchdog_timeout_i || (|gpio_chg));
        wake_pat = watchdog_timeout_i ? `RSRC_PAT_WAKE_WDT : `RSRC_PAT_WAKE_GPIO;
        wdt_irq_evt = in_run && !stop_q && watchdog_timeout_i && !opt_q[`RSRC_OPT_WATCHDOG_RESET_OPTION];
        dly_len = opt_q[`RSRC_OPT_XTAL] ? WAKE_LONG_CYC : WAKE_SHORT_CYC;
    end

    // Previous GPIO levels for edge detection
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            gpio_prev_q <= '0;
        end else begin
            gpio_prev_q <= gpio_i;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************

    rsrc_delay_cnt #(
        .DLY_W(DLY_W)
    ) u_delay (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .start_i(start_q),
        .len_i(dly_len),
        .done_o(dly_done)
    );

    // Block reset is treated as a power-on: hold, delay, then release
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_q <= RSRC_HOLD;
            sys_q <= 1'b1;
            pat_q <= `RSRC_PAT_POR;
            cpu_rst_q <= 1'b1;
            chip_rst_q <= 1'b1;
            pin_oe_n_q <= 1'b0;
            start_q <= 1'b0;
            rel_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            rel_q <= 1'b0;
            unique case (state_q)
                RSRC_RUN: begin
                    if (sys_evt) begin
                        state_q <= por_src ? RSRC_HOLD : RSRC_DELAY;
                        start_q <= !por_src;
                        sys_q <= 1'b1;
                        pat_q <= sys_pat;
                        cpu_rst_q <= 1'b1;
                        chip_rst_q <= 1'b1;
                        pin_oe_n_q <= 1'b0;
                    end else if (wake_evt) begin
                        state_q <= RSRC_DELAY;
                        start_q <= 1'b1;
                        sys_q <= 1'b0;
                        pat_q <= wake_pat;
                        cpu_rst_q <= 1'b1;
                    end
                end
                RSRC_HOLD: begin
                    if (!por_src) begin
                        state_q <= RSRC_DELAY;
                        start_q <= 1'b1;
                    end
                end
                RSRC_DELAY: begin
                    if (por_src) begin
                        state_q <= RSRC_HOLD;
                        sys_q <= 1'b1;
                        pat_q <= `RSRC_PAT_POR;
                        chip_rst_q <= 1'b1;
                        pin_oe_n_q <= 1'b0;
                    end else if (dly_done && sys_q) begin
                        state_q <= RSRC_WAIT_PIN;
                        pin_oe_n_q <= 1'b1;
                    end else if (dly_done) begin
                        state_q <= RSRC_RUN;
                        cpu_rst_q <= 1'b0;
                        rel_q <= 1'b1;
                    end
                end
                RSRC_WAIT_PIN: begin
                    if (por_src) begin
                        state_q <= RSRC_HOLD;
                        pat_q <= `RSRC_PAT_POR;
                        pin_oe_n_q <= 1'b0;
                    end else if (pin_s2_q) begin
                        state_q <= RSRC_RUN;
                        cpu_rst_q <= 1'b0;
                        chip_rst_q <= 1'b0;
                        rel_q <= 1'b1;
                    end
                end
                default: begin
                    state_q <= RSRC_HOLD;
                end
            endcase
        end
    end

    // Stop is entered only from run and left by any reset or wake
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            stop_q <= 1'b0;
        end else if (!in_run || sys_evt || wake_evt) begin
            stop_q <= 1'b0;
        end else if (stop_enter_i && !cpu_rst_q) begin
            stop_q <= 1'b1;
        end
    end

    // Cause flags: a release wins over a clearing read
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            cause_q <= `RSRC_PAT_NONE;
        end else if (rel_q) begin
            cause_q <= pat_q;
        end else if (rd_hs && axi_req_i.araddr == `RSRC_OFF_CAUSE) begin
            cause_q <= `RSRC_PAT_NONE;
        end
    end

    // Watchdog interrupt, deferred past a wake sequence
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            irq_pend_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            irq_q <= wdt_irq_evt || (rel_q && irq_pend_q);
            if (wake_evt && watchdog_timeout_i && !opt_q[`RSRC_OPT_WATCHDOG_RESET_OPTION]) begin
                irq_pend_q <= 1'b1;
            end else if (rel_q || sys_evt) begin
                irq_pend_q <= 1'b0;
            end
        end
    end

    // Port inputs frozen through stop and the wake delay
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            port_in_q <= '0;
        end else if (in_run && !stop_q) begin
            port_in_q <= gpio_i;
        end
    end

    // Open-drain pin data and fixed vector address
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pin_out_q <= 1'b0;
            vec_q <= `RSRC_VECTOR_ADDR;
        end else begin
            pin_out_q <= 1'b0;
            vec_q <= `RSRC_VECTOR_ADDR;
        end
    end

    // ****************************************
    // Software registers
    // ****************************************

    // Option bits and wake enables survive system resets
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            opt_q <= `RSRC_OPT_RST;
            wake_en_q <= '0;
        end else if (wr_hs && axi_req_i.wstrb[0]) begin
            if (axi_req_i.awaddr == `RSRC_OFF_OPT) begin
                opt_q <= axi_req_i.wdata[7:0];
            end
            if (axi_req_i.awaddr == `RSRC_OFF_WAKE_EN) begin
                wake_en_q <= axi_req_i.wdata[GPIO_W-1:0];
            end
        end
    end

    // Oscillator control: system reset restores, wake forces the INTERNAL_PRECISION_OSCILLATOR on
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            osc_q <= `RSRC_OSC_RST;
        end else if (sys_evt) begin
            osc_q <= `RSRC_OSC_RST;
        end else if (wake_evt) begin
            osc_q <= osc_q | `RSRC_OSC_FORCE;
        end else if (wr_hs && axi_req_i.wstrb[0] && axi_req_i.awaddr == `RSRC_OFF_OSC) begin
            osc_q <= axi_req_i.wdata[7:0];
        end
    end

    // Debugger reset request, cleared once the reset is under way
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            dbg_rst_q <= 1'b0;
        end else if (!in_run && sys_q) begin
            dbg_rst_q <= 1'b0;
        end else if (wr_hs && axi_req_i.wstrb[0] && axi_req_i.awaddr == `RSRC_OFF_DBGCTL) begin
            dbg_rst_q <= axi_req_i.wdata[`RSRC_DBG_RST_BIT];
        end
    end

    // ****************************************
    // AXI4-Lite slave
    // ****************************************

    // Read mux; unmapped addresses answer with an error
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_map = 1'b1;
        wr_map = (axi_req_i.awaddr <= `RSRC_OFF_STATUS) && (axi_req_i.awaddr[1:0] == 2'h0);
        unique case (axi_req_i.araddr)
            `RSRC_OFF_CAUSE: rd_mux = {24'h00_0000, cause_q, 4'h0};
            `RSRC_OFF_DBGCTL: rd_mux = {31'h0000_0000, dbg_rst_q};
            `RSRC_OFF_OPT: rd_mux = {24'h00_0000, opt_q};
            `RSRC_OFF_OSC: rd_mux = {24'h00_0000, osc_q};
            `RSRC_OFF_WAKE_EN: rd_mux = 32'(wake_en_q);
            `RSRC_OFF_STATUS: rd_mux = {22'h00_0000, cpu_rst_q, stop_q, 8'(port_in_q)};
            default: rd_map = 1'b0;
        endcase
    end

    assign wr_hs = axi_req_i.awvalid && axi_req_i.wvalid && rsp_q.awready;
    assign rd_hs = axi_req_i.arvalid && rsp_q.arready;

    // Address and data taken together; one write and one read in flight
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rsp_q <= '0;
        end else begin
            rsp_q.awready <= axi_req_i.awvalid && axi_req_i.wvalid && !rsp_q.awready
                && !rsp_q.bvalid;
            rsp_q.wready <= axi_req_i.awvalid && axi_req_i.wvalid && !rsp_q.awready
                && !rsp_q.bvalid;
            if (wr_hs) begin
                rsp_q.bvalid <= 1'b1;
                rsp_q.bresp <= wr_map ? `RSRC_RESP_OKAY : `RSRC_RESP_SLVERR;
            end else if (axi_req_i.bready) begin
                rsp_q.bvalid <= 1'b0;
            end
            rsp_q.arready <= axi_req_i.arvalid && !rsp_q.arready && !rsp_q.rvalid;
            if (rd_hs) begin
                rsp_q.rvalid <= 1'b1;
                rsp_q.rdata <= rd_mux;
                rsp_q.rresp <= rd_map ? `RSRC_RESP_OKAY : `RSRC_RESP_SLVERR;
            end else if (axi_req_i.rready) begin
                rsp_q.rvalid <= 1'b0;
            end
        end
    end

    // Outputs, all straight from flops
    assign axi_rsp_o = rsp_q;
    assign reset_pin_o = pin_out_q;
    assign reset_pin_oe_n_o = pin_oe_n_q;
    assign cpu_reset_o = cpu_rst_q;
    assign chip_reset_o = chip_rst_q;
    assign vector_fetch_o = rel_q;
    assign vector_addr_o = vec_q;
    assign watchdog_irq_o = irq_q;
    assign stop_mode_o = stop_q;
    assign ipo_enable_o = osc_q[0];
    assign sysclk_ipo_sel_o = osc_q[1];
    assign port_input_registers_o = port_in_q;

    // ****************************************
    // Checks
    // ****************************************
    localparam int SHORT_CHK = int'(WAKE_SHORT_CYC) + 1;

    chk_run_pin_qual: assert property (@(posedge core_clk_i) disable iff (reset_i)
        in_run && !stop_q && power_good_i && !brownout_detect_i && low_cnt_q == 3'h4
        |=> state_q == RSRC_DELAY && pat_q == `RSRC_PAT_EXT)
        else $error("pin low four clocks did not reset");
    chk_stop_glitch: assert property (@(posedge core_clk_i) disable iff (reset_i)
        in_run && stop_q && !por_src && low_cnt_q == 3'h1 && debug_pin_i && !watchdog_timeout_i
        && gpio_chg == '0 |=> in_run)
        else $error("short stop pulse caused reset");
    chk_dbg_clear: assert property (@(posedge core_clk_i) disable iff (reset_i)
        in_run && !stop_q && dbg_rst_q && !por_src ##1 !in_run |=> !dbg_rst_q)
        else $error("debugger request did not clear");
    chk_por_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !power_good_i |=> cpu_rst_q && chip_rst_q && state_q == RSRC_HOLD)
        else $error("supply loss did not hold reset");
    chk_cause_load: assert property (@(posedge core_clk_i) disable iff (reset_i)
        rel_q |=> cause_q == $past(pat_q))
        else $error("cause flags not loaded at release");
    chk_wdt_irq: assert property (@(posedge core_clk_i) disable iff (reset_i)
        wdt_irq_evt |=> irq_q && !cpu_rst_q)
        else $error("watchdog interrupt mode misbehaved");
    chk_wait_pin: assert property (@(posedge core_clk_i) disable iff (reset_i)
        state_q == RSRC_WAIT_PIN && !pin_s2_q |=> cpu_rst_q)
        else $error("left reset with pin low");
    chk_pin_drive: assert property (@(posedge core_clk_i) disable iff (reset_i)
        state_q == RSRC_DELAY && sys_q |-> !pin_oe_n_q && chip_rst_q)
        else $error("reset pin not driven during delay");
    chk_wake_len: assert property (@(posedge core_clk_i) disable iff (reset_i)
        start_q && !opt_q[`RSRC_OPT_XTAL] |-> ##[SHORT_CHK:SHORT_CHK] dly_done)
        else $error("short delay length wrong");
    chk_wake_osc: assert property (@(posedge core_clk_i) disable iff (reset_i)
        wake_evt |=> osc_q[1:0] == 2'h3 && !chip_rst_q)
        else $error("wake did not force oscillator");
    chk_wake_stop: assert property (@(posedge core_clk_i) disable iff (reset_i)
        rel_q && !sys_q |=> cause_q[`RSRC_CAUSE_STOP])
        else $error("stop flag missing after wake");
    cov_ext_reset: cover property (@(posedge core_clk_i) disable iff (reset_i)
        rel_q && pat_q == `RSRC_PAT_EXT);
    cov_gpio_wake: cover property (@(posedge core_clk_i) disable iff (reset_i)
        rel_q && pat_q == `RSRC_PAT_WAKE_GPIO);
    cov_wdt_wake_irq: cover property (@(posedge core_clk_i) disable iff (reset_i)
        rel_q && irq_pend_q);
endmodule

/* shared/rsrc_params.svh */
// Register offsets, field positions, reset values and timing of the reset controller
`ifndef RSRC_PARAMS_SVH
`define RSRC_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define RSRC_OFF_CAUSE 8'h00
`define RSRC_OFF_DBGCTL 8'h04
`define RSRC_OFF_OPT 8'h08
`define RSRC_OFF_OSC 8'h0C
`define RSRC_OFF_WAKE_EN 8'h10
`define RSRC_OFF_STATUS 8'h14

// ****************************************
// Fields and reset values
// ****************************************
`define RSRC_OPT_XTAL 0
`define RSRC_OPT_BO_STOP 1
`define RSRC_OPT_WATCHDOG_RESET_OPTION 2
`define RSRC_OPT_RST 8'h06
`define RSRC_OSC_RST 8'h03
`define RSRC_OSC_FORCE 8'h03
`define RSRC_DBG_RST_BIT 0
`define RSRC_STAT_STOP 8
`define RSRC_STAT_INRST 9
`define RSRC_CAUSE_STOP 2

// Cause patterns {power_on, stop, watchdog, external}
`define RSRC_PAT_NONE 4'h0
`define RSRC_PAT_POR 4'h8
`define RSRC_PAT_EXT 4'h1
`define RSRC_PAT_WDT 4'h2
`define RSRC_PAT_WAKE_GPIO 4'h4
`define RSRC_PAT_WAKE_WDT 4'h6

// ****************************************
// Timing
// ****************************************
`define RSRC_CLK_NS 8
`define RSRC_STOP_GLITCH_NS 12
`define RSRC_STOP_GLITCH_CYC ((`RSRC_STOP_GLITCH_NS + `RSRC_CLK_NS - 1) / `RSRC_CLK_NS)
`define RSRC_RUN_PIN_CYC 4
`define RSRC_VECTOR_ADDR 16'h0002

// Bus answers
`define RSRC_RESP_OKAY 2'h0
`define RSRC_RESP_SLVERR 2'h2

`endif

/* shared/rsrc_pkg.sv */
// Types shared by the reset controller files
package rsrc_pkg;

    // AXI4-Lite request from the master
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } rsrc_axi_req_s;

    // AXI4-Lite answer of the slave
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rsrc_axi_rsp_s;

    // Sequencer states
    typedef enum logic [3:0] {
        RSRC_RUN = 4'h1,
        RSRC_HOLD = 4'h2,
        RSRC_DELAY = 4'h4,
        RSRC_WAIT_PIN = 4'h8
    } rsrc_state_e;

    typedef logic [3:0] rsrc_cause_t;

endpackage

/* core/rsrc_delay_cnt.sv */
// Reset delay counter: one done pulse a fixed number of cycles after start
`timescale 1ns/1ns
`include "rsrc_params.svh"

module rsrc_delay_cnt #(
    parameter int unsigned DLY_W = 13
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Control
    input wire logic start_i,
    input wire logic [DLY_W-1:0] len_i,
    // Result
    output logic done_o
);
    import rsrc_pkg::*;

    logic [DLY_W-1:0] cnt_q;
    logic busy_q;
    logic done_q;

    // A new start reloads, so a stale run never ends a fresh one
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (start_i) begin
            cnt_q <= len_i;
            busy_q <= 1'b1;
            done_q <= 1'b0;
        end else if (busy_q && cnt_q <= {{(DLY_W-1){1'b0}}, 1'b1}) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
        end else begin
            cnt_q <= busy_q ? cnt_q - {{(DLY_W-1){1'b0}}, 1'b1} : cnt_q;
            done_q <= 1'b0;
        end
    end

    assign done_o = done_q;
endmodule

/* tb/rsrc_board.sv */
// Board side of the reset wire: pull-up, external pusher, open-drain device
`timescale 1ns/1ns
module rsrc_board (
    // Device drive and board pusher
    input wire logic oe_n_i,
    input wire logic ext_low_i,
    // Resolved wire level
    output wire logic pin_o
);
    // Pull-up wins unless someone pulls low
    assign pin_o = !(ext_low_i || !oe_n_i);
endmodule

/* tb/tb_reset_and_stop_recovery_control.sv */
// Self-checking bench of the reset and stop-recovery controller
`timescale 1ns/1ns
module tb_reset_and_stop_recovery_control;
    import rsrc_pkg::*;
    logic clk = 0, rst = 1, pg = 0, external_cause_flag = 0, stp = 0, wdt = 0;
    logic [7:0] gp = 8'h00;
    logic [31:0] lf = 32'h0d98_2fb3, d;
    logic [1:0] rp;
    rsrc_axi_req_s rq = '0;
    rsrc_axi_rsp_s rs;
    logic bo = 0, dp = 1;
    wire logic pin, oen, cr, chr, rpo, vf, irq, sm, en, sel;
    wire logic [15:0] va;
    wire logic [7:0] pir;
    int fails = 0, n_checks = 0;
    // Clock of 8 ns
    always #4 clk = ~clk;
    rsrc_board brd (.oe_n_i(oen), .ext_low_i(external_cause_flag), .pin_o(pin));
    rsrc_ctrl #(.WAKE_SHORT_CYC(13'h0008), .WAKE_LONG_CYC(13'h0014)) dut (
        .core_clk_i(clk), .reset_i(rst), .axi_req_i(rq), .axi_rsp_o(rs),
        .power_good_i(pg), .brownout_detect_i(bo), .reset_pin_i(pin),
        .reset_pin_o(rpo), .reset_pin_oe_n_o(oen), .stop_enter_i(stp),
        .watchdog_timeout_i(wdt), .debug_pin_i(dp), .gpio_i(gp),
        .cpu_reset_o(cr), .chip_reset_o(chr), .vector_fetch_o(vf), .vector_addr_o(va),
        .watchdog_irq_o(irq), .stop_mode_o(sm), .ipo_enable_o(en), .sysclk_ipo_sel_o(sel),
        .port_input_registers_o(pir)
    );
    // Shift register stepping the random stream
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic test_done;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Bounded wait for the processor release
    task automatic wt_run;
        int i;
        for (i = 0; i < 300 && cr !== 1'b0; i++) @(posedge clk);
        if (cr !== 1'b0) begin
            fails++;
            test_done;
        end
    endtask
    // One write; each channel dropped at its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int i;
        rq.awvalid <= 1; rq.wvalid <= 1; rq.awaddr <= a; rq.wdata <= v;
        rq.wstrb <= 4'hf; rq.bready <= 1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (rs.awready === 1'b1) rq.awvalid <= 0;
            if (rs.wready === 1'b1) rq.wvalid <= 0;
            if (rs.bvalid === 1'b1) break;
        end
        rq.bready <= 0;
        if (i == 50) begin
            fails++;
            test_done;
        end else begin
            @(posedge clk);
        end
    endtask
    // One read, data and answer kept in d and rp
    task automatic rd(input logic [7:0] a);
        int i;
        rq.arvalid <= 1; rq.araddr <= a; rq.rready <= 1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (rs.arready === 1'b1) rq.arvalid <= 0;
            if (rs.rvalid === 1'b1) break;
        end
        d = rs.rdata; rp = rs.rresp; rq.rready <= 0;
        if (i == 50) begin
            fails++;
            test_done;
        end else begin
            @(posedge clk);
        end
    endtask
    // Hang guard
    initial begin
        #400000;
        fails++;
        test_done;
    end
    // Main sequence
    initial begin
        cyc(2); rst <= 0; cyc(3); pg <= 1; wt_run;
        chk("vf", vf, 1);
        chk("vec", va, 16'h0002);
        rd(8'h00); chk("por", d, 32'h80);
        rd(8'h00); chk("clr", d, 32'h00);
        external_cause_flag <= 1; cyc(2); external_cause_flag <= 0; cyc(12); chk("short", cr, 0);
        external_cause_flag <= 1; cyc(9); chk("long", cr, 1);
        cyc(40); chk("held", cr, 1);
        external_cause_flag <= 0; wt_run; rd(8'h00); chk("ext", d, 32'h10);
        wdt <= 1; cyc(1); wdt <= 0; cyc(3); chk("oe", oen, 0);
        chk("rpo", rpo, 0);
        wt_run; rd(8'h00); chk("wdt", d, 32'h20);
        wr(8'h04, 32'h1); cyc(3); chk("dbg", cr, 1);
        chk("chipd", chr, 1);
        wt_run; rd(8'h04); chk("self", d, 32'h0);
        rd(8'h00); chk("dbgc", d, 32'h80);
        wr(8'h08, 32'h2); wdt <= 1; cyc(1); wdt <= 0; cyc(1);
        chk("irq", irq, 1);
        chk("norst", cr, 0);
        wr(8'h0c, 32'h0); wr(8'h10, 32'hff); stp <= 1; cyc(1); stp <= 0; cyc(3);
        chk("stop", sm, 1);
        lf = nxt(lf); gp <= lf[7:0] | 8'h01; cyc(4);
        chk("wake", cr, 1);
        chk("chipw", chr, 0);
        chk("frz", pir, 0);
        wt_run; rd(8'h00); chk("gpio", d, 32'h40);
        chk("pir", pir, gp);
        rd(8'h0c); chk("osc", d, 32'h3);
        chk("ipo", {sel, en}, 2'h3);
        rd(8'h10); chk("keep", d, 32'hff);
        stp <= 1; cyc(1); stp <= 0; cyc(3); wdt <= 1; cyc(1); wdt <= 0; cyc(3);
        wt_run; cyc(1); chk("sirq", irq, 1);
        rd(8'h00); chk("swdt", d, 32'h60);
        stp <= 1; cyc(1); stp <= 0; cyc(3); dp <= 0; cyc(3); chk("dpin", chr, 1);
        dp <= 1; wt_run; rd(8'h00); chk("dpc", d, 32'h80);
        bo <= 1; cyc(3); chk("bo", cr, 1);
        bo <= 0; wt_run; rd(8'h00); chk("bor", d, 32'h80);
        rd(8'h40); chk("resp", rp, 2'h2);
        test_done;
    end
endmodule
